// file: logic/cmd_opcode_decode.sv
// classifies a control byte into an opcode and tells whether a parameter follows
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module cmd_opcode_decode (
    input wire logic [7:0] value,
    output lcd_cmd_pkg::opcode_t op,
    output logic two_byte
);
    function automatic logic hit(input logic [7:0] v, input logic [7:0] m, input logic [7:0] p);
        hit = ((v & m) == p);
    endfunction

    // exact codes first; masked groups do not overlap them
    always_comb begin
        op = lcd_cmd_pkg::op_none;
        if (hit(value, `MASK_EXACT, `OPC_BIAS_PM)) op = lcd_cmd_pkg::op_bias_pm;
        else if (hit(value, `MASK_EXACT, `OPC_FIXED)) op = lcd_cmd_pkg::op_fixed_lines;
        else if (hit(value, `MASK_EXACT, `OPC_NLINE_INV)) op = lcd_cmd_pkg::op_nline_inv;
        else if (hit(value, `MASK_EXACT, `OPC_SYS_RESET)) op = lcd_cmd_pkg::op_sys_reset;
        else if (hit(value, `MASK_EXACT, `OPC_COM_END)) op = lcd_cmd_pkg::op_com_end;
        else if (hit(value, `MASK_EXACT, `OPC_PART_START)) op = lcd_cmd_pkg::op_part_start;
        else if (hit(value, `MASK_EXACT, `OPC_PART_END)) op = lcd_cmd_pkg::op_part_end;
        else if (hit(value, `MASK_2LSB, `OPC_APC)) op = lcd_cmd_pkg::op_apc;
        else if (hit(value, `MASK_2LSB, `OPC_PART_CTRL)) op = lcd_cmd_pkg::op_partial_ctrl;
        else if (hit(value, `MASK_3LSB, `OPC_RAM_ADDR)) op = lcd_cmd_pkg::op_ram_addr;
        else if (hit(value, `MASK_2LSB, `OPC_LINE_RATE)) op = lcd_cmd_pkg::op_line_rate;
        else if (hit(value, `MASK_3LSB, `OPC_LCD_MAP)) op = lcd_cmd_pkg::op_lcd_map;
        else if (hit(value, `MASK_2LSB, `OPC_GRAY1)) op = lcd_cmd_pkg::op_gray1;
        else if (hit(value, `MASK_2LSB, `OPC_GRAY2)) op = lcd_cmd_pkg::op_gray2;
        else if (hit(value, `MASK_2LSB, `OPC_TEST)) op = lcd_cmd_pkg::op_test;
    end

    // commands that swallow the next control byte as their parameter
    always_comb begin
        unique case (op)
            lcd_cmd_pkg::op_apc, lcd_cmd_pkg::op_bias_pm, lcd_cmd_pkg::op_fixed_lines,
            lcd_cmd_pkg::op_nline_inv, lcd_cmd_pkg::op_test, lcd_cmd_pkg::op_com_end,
            lcd_cmd_pkg::op_part_start, lcd_cmd_pkg::op_part_end: two_byte = 1'b1;
            default: two_byte = 1'b0;
        endcase
    end
endmodule

// file: logic/lcd_cmd_defs.svh
// offsets, field positions, reset values and opcode patterns of the command decoder
// Function
// - the advanced program first byte carries a parameter index 0 to 2 and the next byte is that parameter.
// - the partial display control command loads a two-bit enable field that resets to 00b, disabled.
// - the RAM address control command loads three bits into the address control field, reset 001b.
// - the LCD mapping command loads the low three bits of the LCD control field, reset 000b.
// - the first gray-shade command loads LCD control bits 6:5, reset 01b.
// - the second gray-shade command loads LCD control bits 8:7, reset 10b.
// - the partial display start command sets a 7-bit start row that resets to 0.
// - the partial display end command sets a 7-bit end row that resets to 127.
// - a byte with the select bit low is control information and with it high is display data.
// - reset is active low and returns every command field to its default while held.
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH

// register byte offsets
`define OFF_HOST_BYTE 8'h00
`define OFF_APC 8'h04
`define OFF_LCD_CTRL 8'h08
`define OFF_ADDR_PART 8'h0C
`define OFF_DATA_COUNT 8'h10

// host byte register layout
`define HB_SELECT_BIT 8

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// lcd control field positions
`define LC_MAP_LO 0
`define LC_RATE_LO 3
`define LC_GRAY1_LO 5
`define LC_GRAY2_LO 7
`define LC_PART_LO 9

// reset values
`define APC_RST 8'h00
`define LCD_RST 11'h120
`define AC_RST 3'h1
`define DST_RST 7'h00
`define DEN_RST 7'h7F

// opcode patterns and masks
`define MASK_EXACT 8'hFF
`define MASK_2LSB 8'hFC
`define MASK_3LSB 8'hF8
`define OPC_APC 8'h30
`define OPC_BIAS_PM 8'h81
`define OPC_PART_CTRL 8'h84
`define OPC_RAM_ADDR 8'h88
`define OPC_FIXED 8'h90
`define OPC_LINE_RATE 8'hA0
`define OPC_LCD_MAP 8'hC0
`define OPC_NLINE_INV 8'hC8
`define OPC_GRAY1 8'hD0
`define OPC_GRAY2 8'hD4
`define OPC_SYS_RESET 8'hE2
`define OPC_TEST 8'hE4
`define OPC_COM_END 8'hF1
`define OPC_PART_START 8'hF2
`define OPC_PART_END 8'hF3

// host-side reset timing, for reference of the bench
`define RESET_LOW_US 3
`define RESET_TO_WRITE_MS 10
`define CLK_MHZ 100
`define RESET_LOW_CYCLES (`RESET_LOW_US * `CLK_MHZ)
`define RESET_TO_WRITE_CYCLES (`RESET_TO_WRITE_MS * 1000 * `CLK_MHZ)

`endif

// file: logic/lcd_cmd_pkg.sv
// types shared by the command decoder files
package lcd_cmd_pkg;
    typedef enum logic [3:0] {
        op_none, op_apc, op_bias_pm, op_partial_ctrl, op_ram_addr, op_fixed_lines,
        op_line_rate, op_lcd_map, op_nline_inv, op_gray1, op_gray2, op_sys_reset,
        op_test, op_com_end, op_part_start, op_part_end
    } opcode_t;

    typedef enum logic {st_opcode, st_param} parse_state_t;

    typedef struct packed {
        logic cmd_data_select;
        logic [7:0] value;
    } host_byte_t;

    typedef struct packed {
        logic [2:0][7:0] advanced_program_params;
        logic [10:0] lcd_control_field;
        logic [2:0] ram_addr_ctrl_field;
        logic [6:0] partial_start_row;
        logic [6:0] partial_end_row;
    } ctrl_fields_t;
endpackage

// file: logic/lcd_command_decoder.sv
// command decoder with its axi4-lite register slave and display control fields
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module lcd_command_decoder (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output lcd_cmd_pkg::ctrl_fields_t ctrl_fields,
    output logic param_pending
);
    logic aw_held_q;
    logic [7:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_go;
    logic hb_hit;
    logic hb_take;
    lcd_cmd_pkg::host_byte_t hb;
    lcd_cmd_pkg::opcode_t dec_op;
    logic dec_two;
    logic cmd_byte;
    logic op_take;
    logic param_take;
    lcd_cmd_pkg::parse_state_t st_q;
    lcd_cmd_pkg::opcode_t pend_op_q;
    logic [1:0] apc_idx_q;
    logic [2:0][7:0] apc_q;
    logic [10:0] lcd_q;
    logic [2:0] ac_q;
    logic [6:0] dst_q;
    logic [6:0] den_q;
    logic [15:0] data_count_q;
    logic sys_reset;

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a[7:2] == off[7:2]);
    endfunction

    // write channel: address and data are taken in either order, one write in flight
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_go = aw_held_q && w_held_q;
    assign hb_hit = reg_hit(aw_addr_q, `OFF_HOST_BYTE);
    assign hb_take = wr_go && hb_hit && (w_strb_q[1:0] == 2'b11);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // only the host byte register is writable; the rest answer slave error
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= hb_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read channel: one read at a time, answer one cycle after the address
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= `RESP_OKAY;
            if (reg_hit(s_axi_araddr, `OFF_HOST_BYTE)) begin
                rdata_q <= {31'h0000_0000, st_q == lcd_cmd_pkg::st_param};
            end else if (reg_hit(s_axi_araddr, `OFF_APC)) begin
                rdata_q <= {8'h00, apc_q};
            end else if (reg_hit(s_axi_araddr, `OFF_LCD_CTRL)) begin
                rdata_q <= {21'h00_0000, lcd_q};
            end else if (reg_hit(s_axi_araddr, `OFF_ADDR_PART)) begin
                rdata_q <= {9'h000, den_q, 1'b0, dst_q, 5'h00, ac_q};
            end else if (reg_hit(s_axi_araddr, `OFF_DATA_COUNT)) begin
                rdata_q <= {16'h0000, data_count_q};
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // the select bit splits control bytes from display data
    assign hb = w_data_q[`HB_SELECT_BIT:0];
    assign cmd_byte = hb_take && !hb.cmd_data_select;
    assign op_take = cmd_byte && (st_q == lcd_cmd_pkg::st_opcode);
    assign param_take = cmd_byte && (st_q == lcd_cmd_pkg::st_param);
    assign sys_reset = op_take && (dec_op == lcd_cmd_pkg::op_sys_reset);

    cmd_opcode_decode u_decode (
        .value(hb.value),
        .op(dec_op),
        .two_byte(dec_two)
    );

    // parser: a parameter byte is never decoded as an opcode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= lcd_cmd_pkg::st_opcode;
            pend_op_q <= lcd_cmd_pkg::op_none;
            apc_idx_q <= 2'h0;
        end else if (op_take && dec_two) begin
            st_q <= lcd_cmd_pkg::st_param;
            pend_op_q <= dec_op;
            apc_idx_q <= hb.value[1:0];
        end else if (param_take) begin
            st_q <= lcd_cmd_pkg::st_opcode;
            pend_op_q <= lcd_cmd_pkg::op_none;
        end
    end

    // index 3 is not a parameter slot; its byte is swallowed so the stream stays aligned
    always_ff @(posedge mclk) begin
        if (!rst_b || sys_reset) begin
            apc_q <= {3{`APC_RST}};
        end else if (param_take && pend_op_q == lcd_cmd_pkg::op_apc && apc_idx_q != 2'h3) begin
            apc_q[apc_idx_q] <= hb.value;
        end
    end

    // lcd control field, one subfield per single-byte command
    always_ff @(posedge mclk) begin
        if (!rst_b || sys_reset) begin
            lcd_q <= `LCD_RST;
        end else if (op_take) begin
            unique case (dec_op)
                lcd_cmd_pkg::op_partial_ctrl: lcd_q[`LC_PART_LO +: 2] <= hb.value[1:0];
                lcd_cmd_pkg::op_line_rate: lcd_q[`LC_RATE_LO +: 2] <= hb.value[1:0];
                lcd_cmd_pkg::op_lcd_map: lcd_q[`LC_MAP_LO +: 3] <= hb.value[2:0];
                lcd_cmd_pkg::op_gray1: lcd_q[`LC_GRAY1_LO +: 2] <= hb.value[1:0];
                lcd_cmd_pkg::op_gray2: lcd_q[`LC_GRAY2_LO +: 2] <= hb.value[1:0];
                default: lcd_q <= lcd_q;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b || sys_reset) begin
            ac_q <= `AC_RST;
        end else if (op_take && dec_op == lcd_cmd_pkg::op_ram_addr) begin
            ac_q <= hb.value[2:0];
        end
    end

    // partial display window rows, taken from the parameter byte
    always_ff @(posedge mclk) begin
        if (!rst_b || sys_reset) begin
            dst_q <= `DST_RST;
            den_q <= `DEN_RST;
        end else if (param_take && pend_op_q == lcd_cmd_pkg::op_part_start) begin
            dst_q <= hb.value[6:0];
        end else if (param_take && pend_op_q == lcd_cmd_pkg::op_part_end) begin
            den_q <= hb.value[6:0];
        end
    end

    // display data has no frame buffer here; it is only counted, wrapping at 16 bits
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            data_count_q <= 16'h0000;
        end else if (hb_take && hb.cmd_data_select) begin
            data_count_q <= data_count_q + 16'h0001;
        end
    end

    assign ctrl_fields = '{apc_q, lcd_q, ac_q, dst_q, den_q};
    assign param_pending = (st_q == lcd_cmd_pkg::st_param);

    a_apc_param: assert property (@(posedge mclk) disable iff (!rst_b)
        (param_take && pend_op_q == lcd_cmd_pkg::op_apc && apc_idx_q == 2'h1)
        |=> apc_q[1] == $past(hb.value) && $stable(apc_q[0]) && $stable(apc_q[2]))
        else $error("apc parameter not loaded");
    a_partial_ctrl: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && dec_op == lcd_cmd_pkg::op_partial_ctrl)
        |=> lcd_q[10:9] == $past(hb.value[1:0]))
        else $error("partial control not loaded");
    a_ram_addr: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && hb.value[7:3] == 5'h11) |=> ac_q == $past(hb.value[2:0]))
        else $error("ram address control not loaded");
    a_lcd_map: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && hb.value[7:3] == 5'h18)
        |=> lcd_q[2:0] == $past(hb.value[2:0]) && lcd_q[10:3] == $past(lcd_q[10:3]))
        else $error("lcd mapping not loaded");
    a_gray_one: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && hb.value[7:2] == 6'h34) |=> lcd_q[6:5] == $past(hb.value[1:0]))
        else $error("gray shade 1 not loaded");
    a_gray_two: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && hb.value[7:2] == 6'h35) |=> lcd_q[8:7] == $past(hb.value[1:0]))
        else $error("gray shade 2 not loaded");
    a_start_row: assert property (@(posedge mclk) disable iff (!rst_b)
        (param_take && pend_op_q == lcd_cmd_pkg::op_part_start)
        |=> dst_q == $past(hb.value[6:0]) && $stable(den_q))
        else $error("partial start row not loaded");
    a_end_row: assert property (@(posedge mclk) disable iff (!rst_b)
        (param_take && pend_op_q == lcd_cmd_pkg::op_part_end)
        |=> den_q == $past(hb.value[6:0]) && $stable(dst_q))
        else $error("partial end row not loaded");
    a_data_select: assert property (@(posedge mclk) disable iff (!rst_b)
        (hb_take && hb.cmd_data_select)
        |=> data_count_q == $past(data_count_q) + 16'h0001 && $stable(lcd_q) && $stable(st_q))
        else $error("data byte disturbed control state");
    a_reset_defaults: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rst_b) |-> lcd_q == 11'h120 && ac_q == 3'h1 && dst_q == 7'h00
        && den_q == 7'h7F && st_q == lcd_cmd_pkg::st_opcode)
        else $error("fields not at defaults after reset");
    a_param_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        (op_take && dec_two) |=> param_pending && pend_op_q == $past(dec_op))
        else $error("double-byte command did not await parameter");
endmodule

// file: test/host_bus_model.sv
// host-side axi4-lite master model driving the decoder register bus
`timescale 1ns/1ps
module host_bus_model #(parameter int LIMIT = 200) (
    input wire logic mclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // bus idle at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // each handshake is judged at the rising edge that takes it; releases follow that edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp, output bit ok);
        int n;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < LIMIT && !ok; n++) begin
            @(posedge mclk);
            // released lines show the inverse so a stale value never passes as live
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (bready && bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask

    // single read; data and response taken at the rvalid handshake
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] resp, output bit ok);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < LIMIT && !ok; n++) begin
            @(posedge mclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rready && rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask
endmodule

// file: test/lcd_command_decoder_tb.sv
// self-checking bench: random command stream, register reads, bus errors, resets
`timescale 1ns/1ps
module lcd_command_decoder_tb;
    localparam int SETTLE = 20;
    logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, param_pending;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    lcd_cmd_pkg::ctrl_fields_t ctrl_fields, exp, dflt;
    int err_count = 0;
    int num_checks = 0;
    int pend, pidx, cnt, i, k;
    logic [7:0] base [15] = '{8'h30, 8'h81, 8'h84, 8'h88, 8'h90, 8'hA0, 8'hC0, 8'hC8,
                              8'hD0, 8'hD4, 8'hE2, 8'hF1, 8'hF2, 8'hF3, 8'hE4};
    logic [7:0] fmask [15] = '{8'h00, 8'h00, 8'h03, 8'h07, 8'h00, 8'h03, 8'h07, 8'h00,
                               8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};

    lcd_command_decoder lcd_command_decoder_inst (.mclk(mclk), .rst_b(rst_b),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ctrl_fields(ctrl_fields), .param_pending(param_pending));

    host_bus_model host_bus_model_inst (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // 100 mhz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, g);
            err_count++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // bus wrappers: a timed-out transfer ends the run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit ok;
        host_bus_model_inst.axi_write(a, d, s, resp, ok);
        if (!ok) begin
            err_count++;
            tally_and_finish();
        end
        check("bresp", {62'h0, er}, {62'h0, resp});
    endtask

    task automatic rdreg(input logic [7:0] a, input logic [1:0] er);
        bit ok;
        host_bus_model_inst.axi_read(a, rd, resp, ok);
        if (!ok) begin
            err_count++;
            tally_and_finish();
        end
        check("rresp", {62'h0, er}, {62'h0, resp});
    endtask

    // reference model of the command stream
    function automatic void model_byte(input logic sel, input logic [7:0] b);
        if (sel) begin
            cnt++;
        end else if (pend != 0) begin
            if (pend == 1) exp.advanced_program_params[pidx] = b;
            if (pend == 2) exp.partial_start_row = b[6:0];
            if (pend == 3) exp.partial_end_row = b[6:0];
            pend = 0;
        end else begin
            casez (b)
                8'b0011_00??: begin
                    pend = 1;
                    pidx = b[1:0];
                end
                8'h81, 8'h90, 8'hC8, 8'hF1: pend = 4;
                8'b1110_01??: pend = 4;
                8'b1000_01??: exp.lcd_control_field[10:9] = b[1:0];
                8'b1000_1???: exp.ram_addr_ctrl_field = b[2:0];
                8'b1010_00??: exp.lcd_control_field[4:3] = b[1:0];
                8'b1100_0???: exp.lcd_control_field[2:0] = b[2:0];
                8'b1101_00??: exp.lcd_control_field[6:5] = b[1:0];
                8'b1101_01??: exp.lcd_control_field[8:7] = b[1:0];
                8'hE2: exp = dflt;
                8'hF2: pend = 2;
                8'hF3: pend = 3;
                default: ;
            endcase
        end
    endfunction

    task automatic put_byte(input logic sel, input logic [7:0] b);
        wr(8'h00, {23'h0, sel, b}, 4'hF, 2'h0);
        model_byte(sel, b);
        check("fields", {12'h0, exp}, {12'h0, ctrl_fields});
        check("pending", {63'h0, pend != 0}, {63'h0, param_pending});
    endtask

    task automatic check_regs();
        rdreg(8'h00, 2'h0);
        check("reg 00", {63'h0, pend != 0}, {32'h0, rd});
        rdreg(8'h04, 2'h0);
        check("reg 04", {40'h0, exp.advanced_program_params}, {32'h0, rd});
        rdreg(8'h08, 2'h0);
        check("reg 08", {53'h0, exp.lcd_control_field}, {32'h0, rd});
        rdreg(8'h0C, 2'h0);
        check("reg 0c", {41'h0, exp.partial_end_row, 1'b0, exp.partial_start_row, 5'h0,
              exp.ram_addr_ctrl_field}, {32'h0, rd});
        rdreg(8'h10, 2'h0);
        check("reg 10", {48'h0, cnt[15:0]}, {32'h0, rd});
    endtask

    // reset pulse: short at start, full host minimum mid-run; fields are checked while held
    task automatic do_reset(input int hold);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (hold) @(posedge mclk);
        check("fields in reset", {12'h0, dflt}, {12'h0, ctrl_fields});
        rst_b <= 1'b1;
        exp = dflt;
        pend = 0;
        cnt = 0;
        repeat (SETTLE) @(posedge mclk);
    endtask

    initial begin
        rst_b = 1'b0;
        void'($urandom(32'hc464));
        dflt.advanced_program_params = '0;
        dflt.lcd_control_field = {2'h0, 2'h2, 2'h1, 2'h0, 3'h0};
        dflt.ram_addr_ctrl_field = 3'h1;
        dflt.partial_start_row = 7'h00;
        dflt.partial_end_row = 7'h7F;
        do_reset(2);
        check_regs();
        $display("test reset_defaults done");
        // every listed code once, then random mix; params may look like opcodes
        for (i = 0; i < 120; i++) begin
            k = (i < 15) ? i : $urandom_range(18);
            if (k >= 15) begin
                put_byte(1'b1, 8'($urandom));
            end else begin
                if (pend != 0) put_byte(1'b0, 8'($urandom));
                put_byte(1'b0, base[k] | (8'($urandom) & fmask[k]) |
                         ((k == 0) ? 8'($urandom_range(2)) : 8'h00));
            end
            if (i % 20 == 19) check_regs();
        end
        if (pend != 0) put_byte(1'b0, 8'h5A);
        $display("test command_stream done");
        wr(8'h08, 32'h0000_00C7, 4'hF, 2'h2);
        wr(8'h24, 32'h0000_00C7, 4'hF, 2'h2);
        wr(8'h00, 32'h0000_00C7, 4'h1, 2'h0);
        check("fields after refused", {12'h0, exp}, {12'h0, ctrl_fields});
        rdreg(8'h20, 2'h2);
        check("unmapped read", 64'h0, {32'h0, rd});
        $display("test bus_errors done");
        put_byte(1'b0, 8'hC5);
        put_byte(1'b0, 8'hF3);
        do_reset(300);
        check("fields after reset", {12'h0, dflt}, {12'h0, ctrl_fields});
        check("pending after reset", 64'h0, {63'h0, param_pending});
        check_regs();
        $display("test midrun_reset done");
        tally_and_finish();
    end
endmodule
